// ### rtl/hdc_pkg.sv
package hdc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int OSC_FREQ_HZ = 10000000;
  localparam int SYS_FREQ_HZ = 2500000;
  localparam int SYS_DIV = OSC_FREQ_HZ / SYS_FREQ_HZ;
  localparam int DIV_W = 4;
  localparam int SYS_TAP = 1;
  localparam int ONE_TAP = 2;
  localparam int CELL_TAP = 3;
  // ----------------------------------------
  // Port decode
  // ----------------------------------------
  localparam int SEL_LO = 2;
  localparam int SEL_HI = 7;
  localparam logic [1:0] OFS_COMMAND = 2'h0;
  localparam logic [1:0] OFS_DATA = 2'h1;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [5:0] BASE_RESET = 6'h00;
  // ----------------------------------------
  // Wishbone map (word addresses, byte offsets)
  // ----------------------------------------
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_STAT = 8'h04;
  localparam logic [7:0] WB_CMD = 8'h08;
  localparam logic [7:0] WB_DATA = 8'h0c;
  localparam int CTRL_BASE_LSB = 0;
  localparam int CTRL_RLC = 8;
  localparam int CTRL_DRST = 9;
  localparam int CTRL_DMA = 10;
  localparam int STAT_INIT = 0;
  localparam int STAT_RUN = 1;
  localparam int STAT_REQ0 = 2;
  localparam int STAT_REQ1 = 3;
  localparam int STAT_NE = 4;
endpackage : hdc_pkg

// ### rtl/hdc_clk_div.sv
`timescale 1ns/10ps
module hdc_clk_div #(
  parameter int W = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  output logic [W-1:0] count_o
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  // ----------------------------------------
  // Free running divider
  // ----------------------------------------
  always_comb begin
    cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign count_o = cnt_reg;
endmodule : hdc_clk_div

// ### rtl/hdc_sync.sv
`timescale 1ns/10ps
module hdc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  // ----------------------------------------
  // Two stage synchroniser
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
    end
  end
  assign q_o = s2_reg;
endmodule : hdc_sync

// ### rtl/hdc_host_command_port.sv
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
// Function
// - Reset clears boot and active flags, leaving controller dormant
// - System clock 2.5 MHz and write clocks divided from 10 MHz
// - Active flag drives phantom; boot flag enables PROM boot logic
// - A2..A7 compared with jumper base; equality asserts board select
// - Board select combined with bus control makes I/O strobes
// - Host address passed inward under boot flag control
// - Command write decoded at base with A0 and A1 zero
// - Output cycle latches command byte and sets initialise flag
// - Initialise flag stays set until reset
// - Internal memory read at offset zero drives command onto bus
// - Request latch clear clears requests and presets active flag
// - Data read strobe clears request zero; write strobe clears one
// - CRC clock from write clock when writing, recovered clock else
// - CRC and write logic enabled only while FIFO not empty
// - One master reset clears FIFO and CRC together
// - DMA cycle raises address enable; strobe loads upper address
// - Host status read at base; bit 7 shows command received
// - Host data write latches byte and sets a request latch
module hdc_host_command_port (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] host_addr_i,
  input wire logic [7:0] host_data_i,
  input wire logic host_out_i,
  input wire logic host_inp_i,
  input wire logic [7:0] int_status_i,
  input wire logic int_rd_n_i,
  input wire logic int_wr_n_i,
  input wire logic [1:0] int_addr_i,
  input wire logic write_mode_i,
  input wire logic disk_recovered_clk_i,
  input wire logic fifo_not_empty_i,
  input wire logic dma_cycle_i,
  input wire logic [7:0] dma_upper_addr_i,
  output logic board_select_o,
  output logic phantom_n_o,
  output logic boot_enable_o,
  output logic [15:0] int_addr_o,
  output logic int_addr_oe_o,
  output logic [7:0] int_data_o,
  output logic int_data_oe_o,
  output logic [7:0] host_data_o,
  output logic host_data_oe_o,
  output logic dma_request_zero_o,
  output logic dma_request_one_o,
  output logic sys_clk_o,
  output logic one_clk_o,
  output logic cell_clk_o,
  output logic crc_clk_o,
  output logic crc_enable_o,
  output logic write_enable_o,
  output logic data_reset_o,
  output logic upper_addr_latch_enable_o,
  output logic [7:0] upper_addr_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [15:0] ha;
  logic [7:0] hd;
  logic ho, hi, rdn, wrn, wmode, rclk, fne, dcyc;
  logic [1:0] ia;
  logic [7:0] ist;
  logic [7:0] uad;
  logic [3:0] div;
  hdc_sync #(.W(16)) u_sa (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d_i(host_addr_i), .q_o(ha));
  hdc_sync #(.W(8)) u_sd (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d_i(host_data_i), .q_o(hd));
  hdc_sync #(.W(8)) u_ss (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d_i(int_status_i), .q_o(ist));
  hdc_sync #(.W(8)) u_su (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .d_i(dma_upper_addr_i), .q_o(uad));
  hdc_sync #(.W(10)) u_sc (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .d_i({host_out_i, host_inp_i, int_rd_n_i, int_wr_n_i, write_mode_i,
      disk_recovered_clk_i, fifo_not_empty_i, dma_cycle_i, int_addr_i}),
    .q_o({ho, hi, rdn, wrn, wmode, rclk, fne, dcyc, ia}));
  hdc_clk_div #(.W(hdc_pkg::DIV_W)) u_div (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .count_o(div));

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  logic [5:0] base_reg, base_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] dout_reg, dout_next;
  logic init_reg, init_next, run_reg, run_next;
  logic req0_reg, req0_next, req1_reg, req1_next;
  logic cr_reg, cr_next;
  logic out_d_reg, inp_d_reg;
  logic rlc_pulse, drst_pulse, dma_rd_pulse, dma_wr_pulse;
  logic sel, cmd_wr, dat_wr, out_rise, inp_rise;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic wb_req, wb_wr;

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_wr = wb_req && wb_we_i;
  assign sel = (ha[hdc_pkg::SEL_HI:hdc_pkg::SEL_LO] == base_reg);
  assign out_rise = ho && !out_d_reg;
  assign inp_rise = hi && !inp_d_reg;
  assign cmd_wr = sel && out_rise && (ha[1:0] == hdc_pkg::OFS_COMMAND);
  assign dat_wr = sel && out_rise && (ha[1:0] == hdc_pkg::OFS_DATA);
  assign rlc_pulse = wb_wr && wb_adr_i == hdc_pkg::WB_CTRL && wb_sel_i[1]
    && wb_dat_i[hdc_pkg::CTRL_RLC];
  assign drst_pulse = wb_wr && wb_adr_i == hdc_pkg::WB_CTRL && wb_sel_i[1]
    && wb_dat_i[hdc_pkg::CTRL_DRST];
  assign dma_rd_pulse = wb_wr && wb_adr_i == hdc_pkg::WB_CTRL && wb_sel_i[1]
    && wb_dat_i[hdc_pkg::CTRL_DMA];
  assign dma_wr_pulse = wb_wr && wb_adr_i == hdc_pkg::WB_CTRL && wb_sel_i[1]
    && wb_dat_i[hdc_pkg::CTRL_DMA + 1];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    base_next = base_reg;
    cmd_next = cmd_reg;
    dout_next = dout_reg;
    init_next = init_reg;
    run_next = run_reg;
    req0_next = req0_reg;
    req1_next = req1_reg;
    cr_next = cr_reg;
    if (wb_wr && wb_adr_i == hdc_pkg::WB_CTRL && wb_sel_i[0]) begin
      base_next = wb_dat_i[hdc_pkg::CTRL_BASE_LSB +: 6];
    end
    if (wb_wr && wb_adr_i == hdc_pkg::WB_STAT && wb_sel_i[0]) begin
      cr_next = wb_dat_i[7];
    end
    if (cmd_wr) begin
      cmd_next = hd;
      init_next = 1'b1;
      cr_next = 1'b1;
    end
    // Clears come first so a same cycle set wins
    if (dma_rd_pulse) begin
      req0_next = 1'b0;
    end
    if (dma_wr_pulse) begin
      req1_next = 1'b0;
    end
    if (rlc_pulse) begin
      req0_next = 1'b0;
      req1_next = 1'b0;
      run_next = 1'b1;
    end
    if (dat_wr) begin
      dout_next = hd;
      req0_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      base_reg <= hdc_pkg::BASE_RESET;
      cmd_reg <= hdc_pkg::CMD_RESET;
      dout_reg <= hdc_pkg::CMD_RESET;
      init_reg <= 1'b0;
      run_reg <= 1'b0;
      req0_reg <= 1'b0;
      req1_reg <= 1'b0;
      cr_reg <= 1'b0;
      out_d_reg <= 1'b0;
      inp_d_reg <= 1'b0;
    end else begin
      base_reg <= base_next;
      cmd_reg <= cmd_next;
      dout_reg <= dout_next;
      init_reg <= init_next;
      run_reg <= run_next;
      req0_reg <= req0_next;
      req1_reg <= req1_next;
      cr_reg <= cr_next;
      out_d_reg <= ho;
      inp_d_reg <= hi;
    end
  end

  // ----------------------------------------
  // Wishbone slave, ack one cycle after request
  // ----------------------------------------
  always_comb begin
    ack_next = wb_req;
    rdat_next = '0;
    unique case (wb_adr_i)
      hdc_pkg::WB_CTRL: rdat_next = {26'h0, base_reg};
      hdc_pkg::WB_STAT: rdat_next = {24'h0, cr_reg, 2'h0, fne, req1_reg, req0_reg,
        run_reg, init_reg};
      hdc_pkg::WB_CMD: rdat_next = {24'h0, cmd_reg};
      hdc_pkg::WB_DATA: rdat_next = {24'h0, dout_reg};
      default: rdat_next = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= '0;
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  logic [7:0] idat_next, hdat_next;
  logic idoe_next, hdoe_next, cmd_rb, dat_rb;
  always_comb begin
    cmd_rb = !rdn && wrn && ia == hdc_pkg::OFS_COMMAND;
    dat_rb = dma_rd_pulse;
    idoe_next = cmd_rb || dat_rb;
    idat_next = cmd_rb ? cmd_reg : dout_reg;
    hdoe_next = sel && hi && !ho && ha[1:0] == hdc_pkg::OFS_COMMAND;
    hdat_next = {cr_reg, ist[6:0]};
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      board_select_o <= 1'b0;
      phantom_n_o <= 1'b1;
      boot_enable_o <= 1'b0;
      int_addr_o <= '0;
      int_addr_oe_o <= 1'b0;
      int_data_o <= '0;
      int_data_oe_o <= 1'b0;
      host_data_o <= '0;
      host_data_oe_o <= 1'b0;
      dma_request_zero_o <= 1'b0;
      dma_request_one_o <= 1'b0;
      sys_clk_o <= 1'b0;
      one_clk_o <= 1'b0;
      cell_clk_o <= 1'b0;
      crc_clk_o <= 1'b0;
      crc_enable_o <= 1'b0;
      write_enable_o <= 1'b0;
      data_reset_o <= 1'b0;
      upper_addr_latch_enable_o <= 1'b0;
      upper_addr_o <= '0;
    end else begin
      board_select_o <= sel;
      phantom_n_o <= !run_reg;
      boot_enable_o <= !init_reg;
      int_addr_o <= ha;
      int_addr_oe_o <= init_reg;
      int_data_o <= idat_next;
      int_data_oe_o <= idoe_next;
      host_data_o <= hdat_next;
      host_data_oe_o <= hdoe_next || inp_rise && 1'b0;
      dma_request_zero_o <= req0_reg;
      dma_request_one_o <= req1_reg;
      sys_clk_o <= div[hdc_pkg::SYS_TAP];
      one_clk_o <= div[hdc_pkg::ONE_TAP];
      cell_clk_o <= div[hdc_pkg::CELL_TAP];
      crc_clk_o <= wmode ? div[hdc_pkg::CELL_TAP] : rclk;
      crc_enable_o <= fne;
      write_enable_o <= fne && wmode;
      data_reset_o <= drst_pulse;
      upper_addr_latch_enable_o <= dcyc;
      if (dcyc) begin
        upper_addr_o <= uad;
      end
    end
  end
endmodule : hdc_host_command_port

// ### tb/hdc_host_command_port_assertions.sv
`timescale 1ns/10ps
module hdc_chk_assert (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic fifo_not_empty_i,
  input wire logic dma_cycle_i,
  input wire logic phantom_n_o,
  input wire logic boot_enable_o,
  input wire logic int_addr_oe_o,
  input wire logic sys_clk_o,
  input wire logic crc_enable_o,
  input wire logic write_enable_o,
  input wire logic data_reset_o,
  input wire logic upper_addr_latch_enable_o
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_reset_dormant: assert property (disable iff (1'b0)
    rst_i |=> phantom_n_o && !int_addr_oe_o) else $error("not dormant after reset");
  a_boot_vs_init: assert property (!$past(rst_i) |-> boot_enable_o != int_addr_oe_o)
    else $error("boot and address pass overlap");
  a_init_sticky: assert property (int_addr_oe_o |=> int_addr_oe_o)
    else $error("init flag dropped");
  a_sys_clk_div: assert property ($rose(sys_clk_o) |=>
    sys_clk_o ##1 !sys_clk_o[*2] ##1 sys_clk_o) else $error("system clock not ref/4");
  a_crc_gate_off: assert property (!fifo_not_empty_i[*5] |->
    !crc_enable_o && !write_enable_o) else $error("crc or write live on empty fifo");
  a_crc_gate_on: assert property (fifo_not_empty_i[*5] |-> crc_enable_o)
    else $error("crc idle on filled fifo");
  a_dma_latch_on: assert property (dma_cycle_i[*5] |-> upper_addr_latch_enable_o)
    else $error("address enable low in dma");
  a_dma_latch_off: assert property (!dma_cycle_i[*5] |-> !upper_addr_latch_enable_o)
    else $error("address enable high outside dma");
  a_data_reset_pulse: assert property (data_reset_o |=> !data_reset_o)
    else $error("master reset not a pulse");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
endmodule : hdc_chk_assert

bind hdc_host_command_port hdc_chk_assert i_chk (.ref_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .fifo_not_empty_i, .dma_cycle_i, .phantom_n_o, .boot_enable_o, .int_addr_oe_o,
  .sys_clk_o, .crc_enable_o, .write_enable_o, .data_reset_o, .upper_addr_latch_enable_o);

// ### tb/hdc_host_model.sv
`timescale 1ns/10ps
module hdc_host_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] host_data_i,
  input wire logic host_data_oe_i,
  output logic [15:0] addr_o,
  output logic [7:0] data_o,
  output logic out_o,
  output logic inp_o
);
  // ----
  // Host port cycles
  // ----
  initial begin
    addr_o = 16'hffff;
    data_o = 8'hff;
    out_o = 1'b0;
    inp_o = 1'b0;
  end
  // Released lines flip so a stale value can never look valid
  task automatic idle();
    addr_o <= ~addr_o;
    data_o <= ~data_o;
  endtask : idle
  task automatic out_cyc(input logic [15:0] a, input logic [7:0] d);
    addr_o <= a;
    data_o <= d;
    @(posedge ref_clk_i);
    out_o <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    out_o <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    idle();
    repeat (2) @(posedge ref_clk_i);
  endtask : out_cyc
  task automatic in_cyc(input logic [15:0] a, output logic [7:0] d, output bit ok);
    addr_o <= a;
    ok = 1'b0;
    d = 8'h00;
    @(posedge ref_clk_i);
    inp_o <= 1'b1;
    for (int i = 0; i < 10 && !ok; i++) begin
      @(posedge ref_clk_i);
      ok = (host_data_oe_i === 1'b1);
      d = host_data_i;
    end
    inp_o <= 1'b0;
    @(posedge ref_clk_i);
    idle();
  endtask : in_cyc
endmodule : hdc_host_model

// ### tb/hdc_host_command_port_bench.sv
`timescale 1ns/10ps
module hdc_host_command_port_bench;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, int_status_i = 8'h00, dma_upper_addr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic int_rd_n_i = 1'b1, int_wr_n_i = 1'b1, write_mode_i = 1'b0, disk_recovered_clk_i = 1'b0;
  logic fifo_not_empty_i = 1'b0, dma_cycle_i = 1'b0, h_out, h_inp;
  logic [1:0] int_addr_i = 2'h0;
  logic wb_ack_o, phantom_n_o, boot_enable_o, int_addr_oe_o, int_data_oe_o, host_data_oe_o;
  logic [7:0] int_data_o, host_data_o, upper_addr_o, h_data;
  logic [15:0] h_addr;
  logic dma_request_zero_o, crc_clk_o;
  int n_errors = 0, n_compared = 0;
  // ----
  // Harness
  // ----
  always #50 ref_clk_i = ~ref_clk_i;
  hdc_host_model i_host (.ref_clk_i, .host_data_i(host_data_o), .host_data_oe_i(host_data_oe_o),
    .addr_o(h_addr), .data_o(h_data), .out_o(h_out), .inp_o(h_inp));
  hdc_host_command_port i_dut (.ref_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .host_addr_i(h_addr), .host_data_i(h_data),
    .host_out_i(h_out), .host_inp_i(h_inp), .int_status_i, .int_rd_n_i, .int_wr_n_i, .int_addr_i,
    .write_mode_i, .disk_recovered_clk_i, .fifo_not_empty_i, .dma_cycle_i, .dma_upper_addr_i,
    .board_select_o(), .phantom_n_o, .boot_enable_o, .int_addr_o(), .int_addr_oe_o, .int_data_o,
    .int_data_oe_o, .host_data_o, .host_data_oe_o, .dma_request_zero_o, .dma_request_one_o(),
    .sys_clk_o(), .one_clk_o(), .cell_clk_o(), .crc_clk_o, .crc_enable_o(), .write_enable_o(),
    .data_reset_o(), .upper_addr_latch_enable_o(), .upper_addr_o);
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk_i);
    if (i == 20) begin
      n_errors++;
      close_out();
    end
  endtask : wb
  // ----
  // Tests
  // ----
  initial begin
    logic [31:0] q;
    logic [5:0] b;
    logic [7:0] d, e, s;
    bit ok;
    void'($urandom(32'h0fa4cb4f));
    b = 6'($urandom());
    d = 8'($urandom()) | 8'h01;
    e = 8'($urandom());
    s = 8'($urandom());
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk(32'(phantom_n_o), 32'h1);
    chk(32'(boot_enable_o), 32'h1);
    wb(1'b0, hdc_pkg::WB_STAT, 32'h0, q);
    chk(q, 32'h0);
    $display("test reset done");
    wb(1'b1, hdc_pkg::WB_CTRL, {26'h0, b}, q);
    i_host.out_cyc({8'($urandom()), ~b, 2'b00}, ~d);
    wb(1'b0, hdc_pkg::WB_STAT, 32'h0, q);
    chk(q, 32'h0);
    i_host.out_cyc({8'($urandom()), b, 2'b00}, d);
    wb(1'b0, hdc_pkg::WB_CMD, 32'h0, q);
    chk(q, {24'h0, d});
    wb(1'b0, hdc_pkg::WB_STAT, 32'h0, q);
    chk(q & 32'h81, 32'h81);
    chk(32'({boot_enable_o, int_addr_oe_o}), 32'h1);
    int_rd_n_i <= 1'b0;
    for (int i = 0; i < 10 && int_data_oe_o !== 1'b1; i++) @(posedge ref_clk_i);
    chk(32'(int_data_oe_o), 32'h1);
    chk(32'(int_data_o), 32'(d));
    int_rd_n_i <= 1'b1;
    int_status_i <= s;
    repeat (4) @(posedge ref_clk_i);
    i_host.in_cyc({8'h00, b, 2'b00}, e, ok);
    chk(32'({ok, e}), {23'h0, 1'b1, 1'b1, s[6:0]});
    $display("test command done");
    e = 8'($urandom());
    i_host.out_cyc({8'($urandom()), b, 2'b01}, e);
    wb(1'b0, hdc_pkg::WB_DATA, 32'h0, q);
    chk(q, {24'h0, e});
    chk(32'(dma_request_zero_o), 32'h1);
    wb(1'b0, hdc_pkg::WB_CMD, 32'h0, q);
    chk(q, {24'h0, d});
    i_host.out_cyc({8'h00, b, 2'b00}, 8'h00);
    wb(1'b0, hdc_pkg::WB_STAT, 32'h0, q);
    chk(q & 32'h5, 32'h5);
    wb(1'b1, hdc_pkg::WB_CTRL, {26'h0, b} | 32'hc00, q);
    wb(1'b0, hdc_pkg::WB_STAT, 32'h0, q);
    chk(q & 32'hc, 32'h0);
    chk(32'(dma_request_zero_o), 32'h0);
    wb(1'b1, hdc_pkg::WB_CTRL, {26'h0, b} | 32'h300, q);
    wb(1'b0, hdc_pkg::WB_STAT, 32'h0, q);
    chk({q[1], 30'h0, phantom_n_o}, 32'h80000000);
    wb(1'b0, 8'h10, 32'h0, q);
    chk(q, 32'h0);
    $display("test data done");
    for (int k = 0; k < 30; k++) begin
      fifo_not_empty_i <= 1'($urandom());
      dma_cycle_i <= 1'($urandom());
      write_mode_i <= 1'($urandom());
      dma_upper_addr_i <= 8'($urandom());
      repeat (3) @(posedge ref_clk_i);
      disk_recovered_clk_i <= ~disk_recovered_clk_i;
      wb(1'b0, hdc_pkg::WB_STAT, 32'h0, q);
      chk(32'(q[4]), 32'(fifo_not_empty_i));
      if (dma_cycle_i) chk(32'(upper_addr_o), 32'(dma_upper_addr_i));
      // One more edge lets the toggled read clock clear the synchroniser and output flop
      @(posedge ref_clk_i);
      if (!write_mode_i) chk(32'(crc_clk_o), 32'(disk_recovered_clk_i));
    end
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk(32'({phantom_n_o, boot_enable_o, int_addr_oe_o}), 32'h6);
    $display("test random done");
    close_out();
  end
endmodule : hdc_host_command_port_bench
